// ---- rtl/mcuie_core.sv ----
// Instruction decode and execute core with data, F and S register pages
`timescale 1ns/1ps
`default_nettype none

module mcuie_core #(
  parameter int PC_W     = 10,
  parameter int ROM_W    = 16,
  parameter int STACK_D  = 8,
  parameter int CLK_DIV  = 2
) (
  // Clock and reset
  input  wire logic                                  i_clk_sys,
  input  wire logic                                  i_rst_n,
  // Decoded instruction stream
  input  wire logic                                  i_valid,
  input  wire logic [mcuie_pkg::OP_W-1:0]            i_op,
  input  wire logic [mcuie_pkg::REG_ADDR_W-1:0]      i_reg_addr,
  input  wire logic                                  i_dest,
  input  wire logic [mcuie_pkg::BIT_SEL_W-1:0]       i_bit,
  input  wire logic [7:0]                            i_imm,
  input  wire logic [mcuie_pkg::PAGE_ADDR_W-1:0]     i_page_addr,
  input  wire logic [PC_W-1:0]                       i_target,
  output logic                                       o_ready,
  output logic                                       o_taken,
  // Program ROM table port
  output logic [PC_W-1:0]                            o_rom_addr,
  output logic                                       o_rom_rd,
  input  wire logic [ROM_W-1:0]                      i_rom_data,
  // Watchdog and wake
  input  wire logic                                  i_wdt_timeout,
  input  wire logic                                  i_wake,
  // Core state
  output logic [7:0]                                 o_accumulator,
  output logic                                       o_zero_flag,
  output logic                                       o_half_carry_flag,
  output logic                                       o_carry_flag,
  output logic                                       o_power_down_flag_n,
  output logic                                       o_time_out_flag_n,
  output logic                                       o_halt,
  output logic                                       o_irq_enable,
  output logic [PC_W-1:0]                            o_pc,
  output logic [7:0]                                 o_table_high_byte_reg
);

  // ****************************************
  // Instruction clock divider
  // ****************************************
  logic [$clog2(CLK_DIV+1)-1:0] div_q;
  logic                         tick_q;
  wire                          div_end = (div_q == ($clog2(CLK_DIV+1))'(CLK_DIV - 1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_end ? '0 : div_q + 1'b1;
      tick_q <= div_end;
    end
  end

  // ****************************************
  // Wake pin synchroniser
  // ****************************************
  logic wake_meta_q;
  logic wake_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wake_meta_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      wake_meta_q <= i_wake;
      wake_q      <= wake_meta_q;
    end
  end

  // ****************************************
  // State and storage
  // ****************************************
  logic [7:0]             dreg_q [mcuie_pkg::REG_COUNT];
  logic [7:0]             fpage_q [mcuie_pkg::PAGE_COUNT];
  logic [7:0]             spage_q [mcuie_pkg::PAGE_COUNT];
  logic [PC_W-1:0]        stack_q [STACK_D];
  logic [$clog2(STACK_D)-1:0] sp_q;
  logic [1:0]             busy_q;
  logic                   skip_q;
  logic                   tbl_pend_q;

  // ****************************************
  // Decode
  // ****************************************
  wire take    = tick_q && i_valid && o_ready;
  wire exec    = take && !skip_q;
  wire op_ar   = (i_op == mcuie_pkg::OP_ADD_REG);
  wire op_arc  = (i_op == mcuie_pkg::OP_ADD_REG_CARRY);
  wire op_ai   = (i_op == mcuie_pkg::OP_ADD_IMM);
  wire op_aic  = (i_op == mcuie_pkg::OP_ADD_IMM_CARRY);
  wire op_ld   = (i_op == mcuie_pkg::OP_LOAD_IMMEDIATE);
  wire op_mov  = (i_op == mcuie_pkg::OP_MOVE_ACC_REG);
  wire op_bsc  = (i_op == mcuie_pkg::OP_BIT_TEST_SKIP_CLEAR);
  wire op_bss  = (i_op == mcuie_pkg::OP_BIT_TEST_SKIP_SET);
  wire op_inc  = (i_op == mcuie_pkg::OP_INC_SKIP_ZERO);
  wire op_dec  = (i_op == mcuie_pkg::OP_DEC_SKIP_ZERO);
  wire op_fst  = (i_op == mcuie_pkg::OP_FPAGE_STORE);
  wire op_frd  = (i_op == mcuie_pkg::OP_FPAGE_READ);
  wire op_sst  = (i_op == mcuie_pkg::OP_SPAGE_STORE);
  wire op_srd  = (i_op == mcuie_pkg::OP_SPAGE_READ);
  wire op_cla  = (i_op == mcuie_pkg::OP_CALL_BY_ACCUMULATOR);
  wire op_jpa  = (i_op == mcuie_pkg::OP_JUMP_BY_ACCUMULATOR);
  wire op_tbl  = (i_op == mcuie_pkg::OP_ROM_TABLE_READ);
  wire op_slp  = (i_op == mcuie_pkg::OP_SLEEP);
  wire op_wdc  = (i_op == mcuie_pkg::OP_WATCHDOG_CLEAR_INSTR);
  wire op_ien  = (i_op == mcuie_pkg::OP_IRQ_ENABLE_INSTR);
  wire op_idis = (i_op == mcuie_pkg::OP_IRQ_DISABLE_INSTR);
  wire op_swi  = (i_op == mcuie_pkg::OP_SOFT_IRQ);
  wire op_ret  = (i_op == mcuie_pkg::OP_RETURN);
  wire op_reti = (i_op == mcuie_pkg::OP_RETURN_IRQ_ENABLE);
  wire op_call = (i_op == mcuie_pkg::OP_CALL);
  wire op_goto = (i_op == mcuie_pkg::OP_GOTO);

  wire op_add    = op_ar || op_arc || op_ai || op_aic;
  wire op_incdec = op_inc || op_dec;
  wire op_push   = op_cla || op_call || op_swi;
  wire op_pop    = op_ret || op_reti;
  wire op_branch = op_push || op_pop || op_jpa || op_goto;

  // ****************************************
  // Operand fetch and adder
  // ****************************************
  wire [7:0] reg_val  = dreg_q[i_reg_addr];
  wire       bit_val  = reg_val[i_bit];
  wire       use_imm  = op_ai || op_aic;
  wire [7:0] add_a    = use_imm ? i_imm : reg_val;
  wire       add_cin  = (op_arc || op_aic) && o_carry_flag;
  wire [8:0] add_sum  = {1'b0, add_a} + {1'b0, o_accumulator} + {8'h00, add_cin};
  wire [4:0] add_low  = {1'b0, add_a[3:0]} + {1'b0, o_accumulator[3:0]} + {4'h0, add_cin};
  wire [7:0] step_val = op_inc ? reg_val + 8'h01 : reg_val - 8'h01;
  wire [7:0] result   = op_incdec ? step_val : add_sum[7:0];

  wire fpage_ok  = (i_page_addr >= mcuie_pkg::FPAGE_FIRST);
  wire [7:0] fpage_rd = fpage_ok ? fpage_q[i_page_addr] : mcuie_pkg::ZERO_BYTE;

  wire skip_hit = exec && ((op_bsc && !bit_val) || (op_bss && bit_val)
                  || (op_incdec && (step_val == mcuie_pkg::ZERO_BYTE)));

  // Destination bit steers register-operand results
  wire dest_reg = (op_ar || op_arc || op_incdec) && i_dest;
  wire wr_reg   = exec && (dest_reg || op_mov);
  wire wr_acc   = exec && (((op_ar || op_arc || op_incdec) && !i_dest)
                  || op_ai || op_aic || op_ld || op_frd || op_srd);
  wire [7:0] acc_src = op_ld  ? i_imm :
                       op_frd ? fpage_rd :
                       op_srd ? spage_q[i_page_addr] :
                       result;

  // Accumulator jump, call and table targets stay in the current 256-word page
  wire [PC_W-1:0] acc_target = {o_pc[PC_W-1:8], o_accumulator};
  wire [PC_W-1:0] pc_next    = o_pc + 1'b1;
  wire [PC_W-1:0] pc_d = !take ? o_pc :
                         !exec ? pc_next :
                         (op_cla || op_jpa) ? acc_target :
                         (op_call || op_goto) ? i_target :
                         op_swi ? PC_W'(mcuie_pkg::SOFT_IRQ_VEC) :
                         op_pop ? stack_q[sp_q - 1'b1] :
                         pc_next;

  wire [1:0] cyc = op_swi ? mcuie_pkg::CYC_SOFT_IRQ :
                   op_branch ? mcuie_pkg::CYC_BRANCH :
                   op_tbl ? mcuie_pkg::CYC_TABLE :
                   mcuie_pkg::CYC_ONE;
  wire [1:0] busy_d = exec ? cyc - 1'b1 :
                      (tick_q && busy_q != 2'h0) ? busy_q - 1'b1 : busy_q;
  wire tbl_done = tick_q && tbl_pend_q && (busy_q == 2'h1);

  // Timeout wins over the instruction set for the time-out flag; a sleep in the same cycle still sets halt
  wire to_clear = i_wdt_timeout;
  wire halt_d   = (exec && op_slp) ? 1'b1 :
                  (wake_q || to_clear) ? 1'b0 : o_halt;

  // ****************************************
  // Register pages
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (wr_reg) begin
      dreg_q[i_reg_addr] <= op_mov ? o_accumulator : result;
    end
    if (exec && op_fst && fpage_ok) begin
      fpage_q[i_page_addr] <= o_accumulator;
    end
    if (exec && op_sst) begin
      spage_q[i_page_addr] <= o_accumulator;
    end
    if (exec && op_push) begin
      stack_q[sp_q] <= pc_next;
    end
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pc       <= '0;
      sp_q       <= '0;
      busy_q     <= 2'h0;
      skip_q     <= 1'b0;
      tbl_pend_q <= 1'b0;
      o_halt     <= 1'b0;
      o_ready    <= 1'b0;
      o_taken    <= 1'b0;
      o_rom_rd   <= 1'b0;
      o_rom_addr <= '0;
    end else begin
      o_pc    <= pc_d;
      busy_q  <= busy_d;
      o_halt  <= halt_d;
      o_ready <= (busy_d == 2'h0) && !halt_d;
      o_taken <= take;
      if (exec && op_push) begin
        sp_q <= sp_q + 1'b1;
      end else if (exec && op_pop) begin
        sp_q <= sp_q - 1'b1;
      end
      if (take) begin
        skip_q <= skip_hit;
      end
      o_rom_rd <= exec && op_tbl;
      if (exec && op_tbl) begin
        o_rom_addr <= acc_target;
      end
      tbl_pend_q <= (exec && op_tbl) || (tbl_pend_q && !tbl_done);
    end
  end

  // ****************************************
  // Accumulator and flags
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_accumulator         <= mcuie_pkg::ACC_RESET;
      o_zero_flag           <= 1'b0;
      o_half_carry_flag     <= 1'b0;
      o_carry_flag          <= 1'b0;
      o_table_high_byte_reg <= mcuie_pkg::ZERO_BYTE;
      o_irq_enable          <= 1'b0;
    end else begin
      if (wr_acc) begin
        o_accumulator <= acc_src;
      end else if (tbl_done) begin
        o_accumulator <= i_rom_data[7:0];
      end
      if (tbl_done) begin
        o_table_high_byte_reg <= i_rom_data[ROM_W-1:ROM_W-8];
      end
      if (exec && op_add) begin
        o_zero_flag       <= (add_sum[7:0] == mcuie_pkg::ZERO_BYTE);
        o_half_carry_flag <= add_low[4];
        o_carry_flag      <= add_sum[8];
      end
      if (exec && (op_ien || op_reti)) begin
        o_irq_enable <= 1'b1;
      end else if (exec && (op_idis || op_swi)) begin
        o_irq_enable <= 1'b0;
      end
    end
  end

  // ****************************************
  // Power-down and time-out flags
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_power_down_flag_n <= 1'b1;
      o_time_out_flag_n   <= 1'b1;
    end else begin
      if (exec && op_slp) begin
        o_power_down_flag_n <= 1'b0;
      end else if (to_clear && o_halt) begin
        o_power_down_flag_n <= 1'b0;
      end else if (exec && op_wdc) begin
        o_power_down_flag_n <= 1'b1;
      end
      if (to_clear) begin
        o_time_out_flag_n <= 1'b0;
      end else if (exec && (op_wdc || op_slp)) begin
        o_time_out_flag_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  dest_select_a: assert property (exec && op_ar && !i_dest |=> o_accumulator == $past(add_sum[7:0]))
    else $error("add result missed accumulator");
  carry_out_a: assert property (exec && op_add |=> o_carry_flag == $past(add_sum[8]))
    else $error("carry flag wrong after add");
  sleep_pd_a: assert property (exec && op_slp |=> !o_power_down_flag_n && o_halt)
    else $error("sleep did not halt and clear power-down");
  timeout_flag_a: assert property (i_wdt_timeout |=> !o_time_out_flag_n)
    else $error("time-out flag not cleared");
  fpage_range_a: assert property (exec && op_frd && !fpage_ok |=> o_accumulator == 8'h00)
    else $error("invalid page read not zero");
  skip_arm_a: assert property (exec && op_bss && bit_val |=> skip_q)
    else $error("bit test did not arm skip");
  skip_discard_a: assert property (take && skip_q |=> $stable(o_accumulator) && o_pc == $past(pc_next))
    else $error("discarded instruction had effect");
  incdec_flags_a: assert property (exec && op_incdec |=> $stable(o_carry_flag) && $stable(o_zero_flag))
    else $error("skip counter changed flags");
  call_acc_a: assert property (exec && op_cla |=> o_pc == $past(acc_target) && !o_ready)
    else $error("call by accumulator wrong");
  table_read_a: assert property (exec && op_tbl |=> o_rom_rd ##1 !o_rom_rd)
    else $error("table read strobe wrong");
  load_imm_a: assert property (exec && op_ld |=> o_accumulator == $past(i_imm) && $stable(o_carry_flag))
    else $error("load immediate wrong");
  half_carry_a: assert property (exec && op_add |=> o_half_carry_flag == $past(add_low[4]))
    else $error("half carry flag wrong after add");
  zero_flag_a: assert property (exec && op_add |=> o_zero_flag == ($past(add_sum[7:0]) == 8'h00))
    else $error("zero flag wrong after add");
  dest_reg_a: assert property (exec && (op_ar || op_arc) && i_dest |=> $stable(o_accumulator))
    else $error("register destination changed accumulator");
  step_dest_a: assert property (exec && op_incdec && !i_dest |=> o_accumulator == $past(step_val))
    else $error("skip counter result missed accumulator");
  wdt_clear_a: assert property (exec && op_wdc && !i_wdt_timeout |=> o_power_down_flag_n && o_time_out_flag_n)
    else $error("watchdog clear did not set flags");
  soft_irq_a: assert property (exec && op_swi |=> o_pc == PC_W'(mcuie_pkg::SOFT_IRQ_VEC) && !o_ready)
    else $error("software interrupt vector wrong");
  halt_block_a: assert property (o_halt |-> !o_ready)
    else $error("core ready while halted");

  skip_taken_c: cover property (exec && op_bsc && !bit_val ##[1:8] take);
  soft_irq_c: cover property (exec && op_swi);
  wake_c: cover property (o_halt ##1 !o_halt);
  table_read_c: cover property (exec && op_tbl);

endmodule

`default_nettype wire

// ---- rtl/mcuie_pkg.sv ----
// Constants and types for the instruction execution core
// What this block does
// - Destination bit 0 writes accumulator, 1 writes back the data register
// - Carry set on add carry-out, else cleared
// - Sleep halts core and clears power-down flag; power-up or watchdog clear sets it
// - Time-out flag cleared by watchdog timeout; set by power-up, watchdog clear or sleep
// - Six-bit register address 0x00..0x3F; bit operand picks one of eight bits
// - F-page store/read move accumulator to or from 0x5..0xF, one cycle
// - S-page store/read move accumulator to or from 0x0..0xF, one cycle
// - Bit test skips next when bit clear or set; one cycle, two with skip
// - Increment or decrement, write destination, skip on zero, no flag change
// - Call by accumulator saves return address, jumps to accumulator target, two cycles
// - Table read fetches ROM word, high byte into holding register, two cycles
// - Add register with carry updates zero, half carry and carry in one cycle
// - Add register without carry-in writes selected destination, updates three flags
// - Add immediate with carry stores into accumulator, updates three flags
// - Add immediate without carry-in stores into accumulator, updates three flags
// - Load immediate into accumulator in one cycle, flags untouched
// - Skipped instruction is discarded and a no-operation runs in its place
package mcuie_pkg;

  // ****************************************
  // Operand ranges
  // ****************************************
  localparam int          REG_ADDR_W   = 6;
  localparam int          REG_COUNT    = 64;
  localparam int          PAGE_ADDR_W  = 4;
  localparam int          PAGE_COUNT   = 16;
  localparam logic [3:0]  FPAGE_FIRST  = 4'h5;
  localparam int          BIT_SEL_W    = 3;
  localparam int          OP_W         = 5;

  // ****************************************
  // Instruction cycle counts
  // ****************************************
  localparam logic [1:0]  CYC_ONE      = 2'h1;
  localparam logic [1:0]  CYC_BRANCH   = 2'h2;
  localparam logic [1:0]  CYC_TABLE    = 2'h2;
  localparam logic [1:0]  CYC_SOFT_IRQ = 2'h3;

  // ****************************************
  // Reset values and vectors
  // ****************************************
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam int          SOFT_IRQ_VEC = 8;

  typedef enum logic [OP_W-1:0] {
    OP_NOP, OP_ADD_REG, OP_ADD_REG_CARRY, OP_ADD_IMM, OP_ADD_IMM_CARRY,
    OP_LOAD_IMMEDIATE, OP_MOVE_ACC_REG, OP_BIT_TEST_SKIP_CLEAR, OP_BIT_TEST_SKIP_SET,
    OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO, OP_FPAGE_STORE, OP_FPAGE_READ,
    OP_SPAGE_STORE, OP_SPAGE_READ, OP_CALL_BY_ACCUMULATOR, OP_JUMP_BY_ACCUMULATOR,
    OP_ROM_TABLE_READ, OP_SLEEP, OP_WATCHDOG_CLEAR_INSTR, OP_IRQ_ENABLE_INSTR,
    OP_IRQ_DISABLE_INSTR, OP_SOFT_IRQ, OP_RETURN, OP_RETURN_IRQ_ENABLE,
    OP_CALL, OP_GOTO
  } mcuie_op_t;

endpackage

// ---- dv/mcuie_rom_model.sv ----
// Program ROM model that answers table reads from the core
`timescale 1ns/1ps
`default_nettype none

module mcuie_rom_model #(
  parameter int PC_W = 10
) (
  // Clock
  input  wire logic            i_clk_sys,
  // Table read port
  input  wire logic            i_rd,
  input  wire logic [PC_W-1:0] i_addr,
  output logic      [15:0]     o_data
);
  logic [1:0]  hold_q = 2'h0;
  logic [15:0] word_q = 16'h0f0f;

  // Word derived from the low address byte so that reads within one 256-word page are distinct
  always_ff @(posedge i_clk_sys) begin
    if (i_rd) begin
      word_q <= {i_addr[7:0] ^ 8'h5a, ~i_addr[7:0]};
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      // Two cycles past the capture tick the word starts inverting every cycle; a stale copy would hide late sampling
      word_q <= ~word_q;
    end
  end

  assign o_data = word_q;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the instruction execution core
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int DIV = 2;
  logic       i_clk_sys, i_rst_n, i_valid, i_dest, i_wdt_timeout, i_wake, o_ready, o_taken, o_rom_rd;
  logic       o_zero_flag, o_half_carry_flag, o_carry_flag, o_power_down_flag_n, o_time_out_flag_n;
  logic       o_halt, o_irq_enable;
  logic [4:0] i_op;
  logic [5:0] i_reg_addr;
  logic [2:0] i_bit;
  logic [3:0] i_page_addr;
  logic [7:0] i_imm, o_accumulator, o_table_high_byte_reg;
  logic [9:0] i_target, o_rom_addr, o_pc, tgt;
  logic [15:0] i_rom_data;
  int         mismatches, n_tests, low;

  mcuie_core #(.CLK_DIV(DIV)) u_mcuie_core (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_op(i_op), .i_reg_addr(i_reg_addr),
    .i_dest(i_dest), .i_bit(i_bit), .i_imm(i_imm), .i_page_addr(i_page_addr), .i_target(i_target),
    .o_ready(o_ready), .o_taken(o_taken), .o_rom_addr(o_rom_addr), .o_rom_rd(o_rom_rd),
    .i_rom_data(i_rom_data), .i_wdt_timeout(i_wdt_timeout), .i_wake(i_wake),
    .o_accumulator(o_accumulator), .o_zero_flag(o_zero_flag), .o_half_carry_flag(o_half_carry_flag),
    .o_carry_flag(o_carry_flag), .o_power_down_flag_n(o_power_down_flag_n),
    .o_time_out_flag_n(o_time_out_flag_n), .o_halt(o_halt), .o_irq_enable(o_irq_enable), .o_pc(o_pc),
    .o_table_high_byte_reg(o_table_high_byte_reg));

  mcuie_rom_model u_mcuie_rom_model (.i_clk_sys(i_clk_sys), .i_rd(o_rom_rd), .i_addr(o_rom_addr), .o_data(i_rom_data));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************
  // Checking and access tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic fail(input string what);
    mismatches++;
    $display("BAD t=%0t %s", $time, what);
    results();
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 60 && o_ready !== 1'b1; k++) @(negedge i_clk_sys);
    if (k >= 60) fail("core never ready");
  endtask

  // Holds the instruction until taken; counts cycles with the core busy afterwards, except after sleep
  task automatic issue(input mcuie_pkg::mcuie_op_t op, input logic [7:0] a, input logic [3:0] db, output int busy);
    int k;
    @(posedge i_clk_sys);
    i_valid <= 1'b1;
    i_op <= op;
    i_reg_addr <= a[5:0];
    i_imm <= a;
    i_page_addr <= a[3:0];
    i_dest <= db[3];
    i_bit <= db[2:0];
    i_target <= tgt;
    k = 0;
    do begin
      @(negedge i_clk_sys);
      k++;
    end while (o_taken !== 1'b1 && k < 60);
    if (k >= 60) fail("instruction never taken");
    busy = (o_ready !== 1'b1) ? 1 : 0;
    @(posedge i_clk_sys);
    i_valid <= 1'b0;
    if (op != mcuie_pkg::OP_SLEEP) begin
      for (k = 0; k < 60; k++) begin
        @(negedge i_clk_sys);
        if (o_ready === 1'b1) break;
        busy++;
      end
      if (k >= 60) fail("core stuck busy");
    end
  endtask

  task automatic s(input mcuie_pkg::mcuie_op_t op, input logic [7:0] a, input logic [3:0] db, input int n,
                   input logic [7:0] eacc, input logic [2:0] ef);
    int busy;
    issue(op, a, db, busy);
    chk({o_accumulator, 5'h00, o_zero_flag, o_half_carry_flag, o_carry_flag}, {eacc, 5'h00, ef}, op.name());
    chk(16'(busy), (n == 1) ? 16'h0000 : 16'(DIV * (n - 1)), "busy cycles");
  endtask

  function automatic logic [15:0] status();
    return {13'h0000, o_power_down_flag_n, o_time_out_flag_n, o_halt};
  endfunction

  task automatic wdt_pulse();
    @(posedge i_clk_sys);
    i_wdt_timeout <= 1'b1;
    @(posedge i_clk_sys);
    i_wdt_timeout <= 1'b0;
    @(negedge i_clk_sys);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_rst_n, i_valid, i_dest, i_wdt_timeout, i_wake, i_op, i_reg_addr, i_bit, i_page_addr, i_imm} = '0;
    i_target = 10'h000;
    tgt = 10'h123;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(negedge i_clk_sys);
    chk({o_accumulator, 5'h00, o_zero_flag, o_half_carry_flag, o_carry_flag}, 16'h0000, "reset state");
    chk(status(), 16'h0006, "power-up status");
    $display("test reset done");
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h34, 4'h0, 1, 8'h34, 3'h0);
    s(mcuie_pkg::OP_MOVE_ACC_REG, 8'h3f, 4'h0, 1, 8'h34, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h12, 4'h0, 1, 8'h12, 3'h0);
    s(mcuie_pkg::OP_ADD_IMM, 8'hff, 4'h0, 1, 8'h11, 3'h3);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h12, 4'h0, 1, 8'h12, 3'h3);
    s(mcuie_pkg::OP_ADD_REG_CARRY, 8'h3f, 4'h8, 1, 8'h12, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h00, 4'h0, 1, 8'h00, 3'h0);
    s(mcuie_pkg::OP_ADD_REG, 8'h3f, 4'h0, 1, 8'h47, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'hb9, 4'h0, 1, 8'hb9, 3'h0);
    s(mcuie_pkg::OP_ADD_REG, 8'h3f, 4'h0, 1, 8'h00, 3'h7);
    s(mcuie_pkg::OP_ADD_IMM_CARRY, 8'h0f, 4'h0, 1, 8'h10, 3'h2);
    s(mcuie_pkg::OP_ADD_IMM_CARRY, 8'hf0, 4'h0, 1, 8'h00, 3'h5);
    $display("test arithmetic done");
    s(mcuie_pkg::OP_BIT_TEST_SKIP_CLEAR, 8'h3f, 4'h3, 1, 8'h00, 3'h5);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h99, 4'h0, 1, 8'h00, 3'h5);
    s(mcuie_pkg::OP_BIT_TEST_SKIP_SET, 8'h3f, 4'h3, 1, 8'h00, 3'h5);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h99, 4'h0, 1, 8'h99, 3'h5);
    s(mcuie_pkg::OP_BIT_TEST_SKIP_SET, 8'h3f, 4'h6, 1, 8'h99, 3'h5);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h55, 4'h0, 1, 8'h99, 3'h5);
    s(mcuie_pkg::OP_ADD_IMM, 8'h01, 4'h0, 1, 8'h9a, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'hff, 4'h0, 1, 8'hff, 3'h0);
    s(mcuie_pkg::OP_MOVE_ACC_REG, 8'h00, 4'h0, 1, 8'hff, 3'h0);
    s(mcuie_pkg::OP_INC_SKIP_ZERO, 8'h00, 4'h0, 1, 8'h00, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h77, 4'h0, 1, 8'h00, 3'h0);
    s(mcuie_pkg::OP_DEC_SKIP_ZERO, 8'h00, 4'h8, 1, 8'h00, 3'h0);
    s(mcuie_pkg::OP_ADD_REG, 8'h00, 4'h0, 1, 8'hfe, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h01, 4'h0, 1, 8'h01, 3'h0);
    s(mcuie_pkg::OP_MOVE_ACC_REG, 8'h01, 4'h0, 1, 8'h01, 3'h0);
    s(mcuie_pkg::OP_DEC_SKIP_ZERO, 8'h01, 4'h8, 1, 8'h01, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h33, 4'h0, 1, 8'h01, 3'h0);
    s(mcuie_pkg::OP_ADD_REG, 8'h01, 4'h0, 1, 8'h01, 3'h0);
    $display("test skips done");
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'ha5, 4'h0, 1, 8'ha5, 3'h0);
    s(mcuie_pkg::OP_FPAGE_STORE, 8'h05, 4'h0, 1, 8'ha5, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h5a, 4'h0, 1, 8'h5a, 3'h0);
    s(mcuie_pkg::OP_FPAGE_STORE, 8'h0f, 4'h0, 1, 8'h5a, 3'h0);
    s(mcuie_pkg::OP_SPAGE_STORE, 8'h00, 4'h0, 1, 8'h5a, 3'h0);
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'hc3, 4'h0, 1, 8'hc3, 3'h0);
    s(mcuie_pkg::OP_SPAGE_STORE, 8'h0f, 4'h0, 1, 8'hc3, 3'h0);
    s(mcuie_pkg::OP_FPAGE_READ, 8'h05, 4'h0, 1, 8'ha5, 3'h0);
    s(mcuie_pkg::OP_FPAGE_READ, 8'h0f, 4'h0, 1, 8'h5a, 3'h0);
    s(mcuie_pkg::OP_SPAGE_READ, 8'h0f, 4'h0, 1, 8'hc3, 3'h0);
    s(mcuie_pkg::OP_FPAGE_READ, 8'h04, 4'h0, 1, 8'h00, 3'h0);
    s(mcuie_pkg::OP_SPAGE_READ, 8'h00, 4'h0, 1, 8'h5a, 3'h0);
    $display("test pages done");
    s(mcuie_pkg::OP_GOTO, 8'h00, 4'h0, 2, 8'h5a, 3'h0);
    chk({6'h00, o_pc}, 16'h0123, "goto target");
    tgt = 10'h2a5;
    s(mcuie_pkg::OP_CALL, 8'h00, 4'h0, 2, 8'h5a, 3'h0);
    chk({6'h00, o_pc}, 16'h02a5, "call target");
    s(mcuie_pkg::OP_RETURN, 8'h00, 4'h0, 2, 8'h5a, 3'h0);
    chk({6'h00, o_pc}, 16'h0124, "return address");
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h10, 4'h0, 1, 8'h10, 3'h0);
    s(mcuie_pkg::OP_CALL_BY_ACCUMULATOR, 8'h00, 4'h0, 2, 8'h10, 3'h0);
    chk({6'h00, o_pc}, 16'h0110, "call by accumulator target");
    s(mcuie_pkg::OP_RETURN, 8'h00, 4'h0, 2, 8'h10, 3'h0);
    chk({6'h00, o_pc}, 16'h0126, "saved return address");
    s(mcuie_pkg::OP_JUMP_BY_ACCUMULATOR, 8'h00, 4'h0, 2, 8'h10, 3'h0);
    chk({6'h00, o_pc}, 16'h0110, "jump by accumulator target");
    s(mcuie_pkg::OP_LOAD_IMMEDIATE, 8'h34, 4'h0, 1, 8'h34, 3'h0);
    s(mcuie_pkg::OP_ROM_TABLE_READ, 8'h00, 4'h0, 2, 8'hcb, 3'h0);
    chk({6'h00, o_rom_addr}, 16'h0134, "table address");
    chk({8'h00, o_table_high_byte_reg}, 16'h006e, "table high byte");
    s(mcuie_pkg::OP_IRQ_ENABLE_INSTR, 8'h00, 4'h0, 1, 8'hcb, 3'h0);
    chk({15'h0000, o_irq_enable}, 16'h0001, "irq enabled");
    s(mcuie_pkg::OP_SOFT_IRQ, 8'h00, 4'h0, 3, 8'hcb, 3'h0);
    chk({5'h00, o_irq_enable, o_pc}, 16'h0008, "soft irq vector");
    s(mcuie_pkg::OP_RETURN_IRQ_ENABLE, 8'h00, 4'h0, 2, 8'hcb, 3'h0);
    chk({5'h00, o_irq_enable, o_pc}, 16'h0514, "return with irq enable");
    s(mcuie_pkg::OP_IRQ_DISABLE_INSTR, 8'h00, 4'h0, 1, 8'hcb, 3'h0);
    chk({15'h0000, o_irq_enable}, 16'h0000, "irq disabled");
    $display("test flow done");
    issue(mcuie_pkg::OP_SLEEP, 8'h00, 4'h0, low);
    @(negedge i_clk_sys);
    chk(status(), 16'h0003, "sleep status");
    @(posedge i_clk_sys);
    i_wake <= 1'b1;
    wait_ready();
    @(posedge i_clk_sys);
    i_wake <= 1'b0;
    @(negedge i_clk_sys);
    chk(status(), 16'h0002, "woken status");
    s(mcuie_pkg::OP_WATCHDOG_CLEAR_INSTR, 8'h00, 4'h0, 1, 8'hcb, 3'h0);
    chk(status(), 16'h0006, "watchdog clear status");
    wdt_pulse();
    chk(status(), 16'h0004, "timeout status");
    s(mcuie_pkg::OP_WATCHDOG_CLEAR_INSTR, 8'h00, 4'h0, 1, 8'hcb, 3'h0);
    chk(status(), 16'h0006, "cleared after timeout");
    issue(mcuie_pkg::OP_SLEEP, 8'h00, 4'h0, low);
    wdt_pulse();
    wait_ready();
    chk(status(), 16'h0000, "timeout in halt");
    $display("test power flags done");
    results();
  end
endmodule
`default_nettype wire
